// file: tbdt_pkg.sv
// package for the driver test and self-test extension block
// assumes a 100 MHz system clock and an APB register slave
package tbdt_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_EXT = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TALLY_LSB = 8;
	localparam int TALLY_MSB = 15;
	localparam int CONT_BIT = 5;
	localparam int PATEN_BIT = 4;
	localparam int GAP_BIT = 2;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 1;
	localparam int CTRL_JABBER_BIT = 0;
	localparam int CTRL_SELFTEST_BIT = 1;
	localparam int IRQ_SAT_BIT = 0;
	localparam int IRQ_SEQ_BIT = 1;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TALLY_RESET = 8'h00;
	localparam logic [7:0] TALLY_MAX = 8'hFF;
	localparam logic [15:0] EXT_WRITE_MASK = 16'h0037;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int GAP_SHORT_US = 10;
	localparam int GAP_LONG_US = 15;
	localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
	localparam int GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
	localparam int SEQ_BURST_CYC = 64;
	// ----------------------------------------
	// pattern codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		PAT_DATA_END_OF_PACKET_VARIANT_0 = 2'h0,
		PAT_DATA_END_OF_PACKET_VARIANT_1 = 2'h1,
		PAT_LINK_PULSE = 2'h2,
		PAT_MANCHESTER_ONES = 2'h3
	} tbdt_pattern_t;
endpackage : tbdt_pkg

// file: tbdt_driver_test.sv
// driver test pattern control, self-test error tally and continuous mode
// assumes APB master on clk_sys; error strobes from the receive checker on clk_sys
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
//
// Function
// - count errored self-test nibbles in bits 15:8
// - restart of self-test clears the tally
// - tally sticks at its maximum
// - bit 5 sends continuous gapless random data
// - bit 4 enables driver pattern at 10M only, resets 0
// - bit 2 picks 15us or 10us gap
// - select field chooses one of four patterns
// - jabber off acts only at 10M
module tbdt_driver_test (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// transceiver status
	input wire logic speed10,
	input wire logic selftestStart,
	input wire logic nibbleError,
	// driver and self-test controls
	output logic patternActive,
	output logic [1:0] patternSelect,
	output logic sequenceGapActive,
	output logic sequenceSend,
	output logic continuousSend,
	output logic jabberOff,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] selftestErrorTally;
	logic selftestContinuous;
	logic driverPatternEnable;
	logic patternGapSelect;
	logic [1:0] driverPatternSelect;
	logic [1:0] reservedHigh;
	logic reservedLow;
	logic [1:0] ctrl;
	logic [1:0] irqStatus;
	logic [1:0] irqMask;
	logic selftestRun;
	logic selftestRunDly;
	logic [11:0] gapCount;
	logic [11:0] gapLimit;
	logic tallySatEvent;
	logic seqEvent;
	logic wrEn;
	logic rdEn;
	logic restart;

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign selftestRun = ctrl[tbdt_pkg::CTRL_SELFTEST_BIT] | selftestStart;
	assign restart = selftestRun && !selftestRunDly;

	// ----------------------------------------
	// writable fields
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			selftestContinuous <= 1'b0;
			driverPatternEnable <= 1'b0;
			patternGapSelect <= 1'b0;
			driverPatternSelect <= 2'h0;
			reservedHigh <= 2'h0;
			reservedLow <= 1'b0;
		end else if (wrEn && paddr == tbdt_pkg::ADDR_EXT) begin
			selftestContinuous <= pwdata[tbdt_pkg::CONT_BIT];
			driverPatternEnable <= pwdata[tbdt_pkg::PATEN_BIT];
			patternGapSelect <= pwdata[tbdt_pkg::GAP_BIT];
			driverPatternSelect <= pwdata[tbdt_pkg::SEL_MSB:tbdt_pkg::SEL_LSB];
			reservedHigh <= pwdata[7:6];
			reservedLow <= pwdata[3];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl <= tbdt_pkg::CTRL_RESET;
		end else if (wrEn && paddr == tbdt_pkg::ADDR_CTRL) begin
			ctrl <= pwdata[1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irqMask <= tbdt_pkg::IRQ_RESET;
		end else if (wrEn && paddr == tbdt_pkg::ADDR_IRQ_MASK) begin
			irqMask <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// error tally
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			selftestRunDly <= 1'b0;
		end else begin
			selftestRunDly <= selftestRun;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			selftestErrorTally <= tbdt_pkg::TALLY_RESET;
		end else if (restart) begin
			selftestErrorTally <= tbdt_pkg::TALLY_RESET;
		end else if (selftestRun && nibbleError && selftestErrorTally != tbdt_pkg::TALLY_MAX) begin
			selftestErrorTally <= selftestErrorTally + 8'h01;
		end
	end
	assign tallySatEvent = !restart && selftestRun && nibbleError && selftestErrorTally == 8'hFE;

	// ----------------------------------------
	// pattern sequencer with gap
	// ----------------------------------------
	assign gapLimit = patternGapSelect ? 12'(tbdt_pkg::GAP_LONG_CYC) : 12'(tbdt_pkg::GAP_SHORT_CYC);

	always_ff @(posedge clk_sys) begin
		if (reset || !patternActive) begin
			gapCount <= 12'h000;
		end else if (gapCount >= gapLimit + 12'(tbdt_pkg::SEQ_BURST_CYC) - 12'h001) begin
			gapCount <= 12'h000;
		end else begin
			gapCount <= gapCount + 12'h001;
		end
	end
	assign seqEvent = patternActive && gapCount == 12'h000;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			patternActive <= 1'b0;
			patternSelect <= 2'h0;
			sequenceGapActive <= 1'b0;
			sequenceSend <= 1'b0;
			continuousSend <= 1'b0;
			jabberOff <= 1'b0;
		end else begin
			patternActive <= driverPatternEnable && speed10;
			patternSelect <= driverPatternSelect;
			sequenceSend <= patternActive && (driverPatternSelect == tbdt_pkg::PAT_MANCHESTER_ONES
				|| gapCount < 12'(tbdt_pkg::SEQ_BURST_CYC));
			sequenceGapActive <= patternActive && driverPatternSelect != tbdt_pkg::PAT_MANCHESTER_ONES
				&& gapCount >= 12'(tbdt_pkg::SEQ_BURST_CYC);
			continuousSend <= selftestContinuous && selftestRun;
			jabberOff <= ctrl[tbdt_pkg::CTRL_JABBER_BIT] && speed10;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irqStatus <= tbdt_pkg::IRQ_RESET;
		end else begin
			// clear only the bits the read returned; later events survive
			irqStatus <= ((rdEn && paddr == tbdt_pkg::ADDR_IRQ_STATUS) ? irqStatus & ~prdata[1:0] : irqStatus)
				| {seqEvent, tallySatEvent};
		end
	end
	assign irq = |(irqStatus & irqMask);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				tbdt_pkg::ADDR_EXT: prdata <= {16'h0000, selftestErrorTally, reservedHigh, selftestContinuous,
					driverPatternEnable, reservedLow, patternGapSelect, driverPatternSelect};
				tbdt_pkg::ADDR_CTRL: prdata <= {30'h0, ctrl};
				tbdt_pkg::ADDR_IRQ_STATUS: prdata <= {30'h0, irqStatus};
				tbdt_pkg::ADDR_IRQ_MASK: prdata <= {30'h0, irqMask};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// check helpers
	// ----------------------------------------
	logic [11:0] gapRunCount;
	logic [11:0] burstRunCount;

	// length of the gap in progress
	always_ff @(posedge clk_sys) begin
		if (reset || !sequenceGapActive) begin
			gapRunCount <= 12'h000;
		end else begin
			gapRunCount <= gapRunCount + 12'h001;
		end
	end

	// length of the burst in progress, not for the endless pattern
	always_ff @(posedge clk_sys) begin
		if (reset || !sequenceSend || patternSelect == tbdt_pkg::PAT_MANCHESTER_ONES) begin
			burstRunCount <= 12'h000;
		end else begin
			burstRunCount <= burstRunCount + 12'h001;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_tally_count: assert property (@(posedge clk_sys) disable iff (reset)
		selftestRun && !restart && nibbleError && selftestErrorTally < 8'hFF
		|=> selftestErrorTally == $past(selftestErrorTally) + 8'h01)
		else $error("tally did not count");
	chk_tally_restart: assert property (@(posedge clk_sys) disable iff (reset)
		restart |=> selftestErrorTally == 8'h00)
		else $error("tally not cleared on restart");
	chk_tally_sticks: assert property (@(posedge clk_sys) disable iff (reset)
		selftestErrorTally == 8'hFF && !restart |=> selftestErrorTally == 8'hFF)
		else $error("tally left maximum");
	chk_cont_send: assert property (@(posedge clk_sys) disable iff (reset)
		selftestContinuous && selftestRun |=> continuousSend)
		else $error("continuous send missing");
	chk_cont_needs_run: assert property (@(posedge clk_sys) disable iff (reset)
		!selftestRun |=> !continuousSend)
		else $error("continuous without self-test");
	chk_pattern_enable: assert property (@(posedge clk_sys) disable iff (reset)
		!driverPatternEnable |=> !patternActive ##1 !sequenceSend)
		else $error("pattern active while disabled");
	chk_gap_length: assert property (@(posedge clk_sys) disable iff (reset)
		patternActive && gapCount == 12'h000 |-> gapLimit == (patternGapSelect ? 12'h5DC : 12'h3E8))
		else $error("wrong gap length");
	chk_pattern_select: assert property (@(posedge clk_sys) disable iff (reset)
		1'b1 |=> patternSelect == $past(driverPatternSelect))
		else $error("pattern select not followed");
	chk_gap_run: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(sequenceGapActive) && sequenceSend && patternSelect != tbdt_pkg::PAT_MANCHESTER_ONES
		|-> gapRunCount == gapLimit)
		else $error("gap ran for wrong length");
	chk_burst_run: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(sequenceSend) && sequenceGapActive |-> burstRunCount == 12'(tbdt_pkg::SEQ_BURST_CYC))
		else $error("burst ran for wrong length");
	chk_gap_exclusive: assert property (@(posedge clk_sys) disable iff (reset)
		!(sequenceSend && sequenceGapActive))
		else $error("burst and gap together");
	chk_manchester_send: assert property (@(posedge clk_sys) disable iff (reset)
		patternActive && driverPatternSelect == tbdt_pkg::PAT_MANCHESTER_ONES |=> sequenceSend)
		else $error("manchester pattern not sent");
	chk_manchester_nogap: assert property (@(posedge clk_sys) disable iff (reset)
		driverPatternSelect == tbdt_pkg::PAT_MANCHESTER_ONES |=> !sequenceGapActive)
		else $error("gap in manchester pattern");
	chk_pattern_speed: assert property (@(posedge clk_sys) disable iff (reset)
		!speed10 |=> !patternActive)
		else $error("pattern active outside 10M");
	chk_pattern_on: assert property (@(posedge clk_sys) disable iff (reset)
		driverPatternEnable && speed10 |=> patternActive)
		else $error("pattern not active");
	chk_jabber_on: assert property (@(posedge clk_sys) disable iff (reset)
		ctrl[tbdt_pkg::CTRL_JABBER_BIT] && speed10 |=> jabberOff)
		else $error("jabber off not applied");
	chk_jabber_ctrl: assert property (@(posedge clk_sys) disable iff (reset)
		!ctrl[tbdt_pkg::CTRL_JABBER_BIT] |=> !jabberOff)
		else $error("jabber off without request");
	chk_cont_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!selftestContinuous |=> !continuousSend)
		else $error("continuous send without mode");
	chk_fields_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!(wrEn && paddr == tbdt_pkg::ADDR_EXT) |=> $stable(driverPatternEnable) && $stable(patternGapSelect)
		&& $stable(driverPatternSelect) && $stable(selftestContinuous))
		else $error("field changed without write");
	chk_ctrl_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!(wrEn && paddr == tbdt_pkg::ADDR_CTRL) |=> $stable(ctrl))
		else $error("control changed without write");
	chk_tally_idle: assert property (@(posedge clk_sys) disable iff (reset)
		!selftestRun |=> $stable(selftestErrorTally))
		else $error("tally moved while idle");
	chk_tally_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		!nibbleError && !restart |=> $stable(selftestErrorTally))
		else $error("tally moved without error");
	chk_sat_flag: assert property (@(posedge clk_sys) disable iff (reset)
		tallySatEvent |=> irqStatus[tbdt_pkg::IRQ_SAT_BIT])
		else $error("saturation flag not set");
	chk_sat_clear: assert property (@(posedge clk_sys) disable iff (reset)
		rdEn && paddr == tbdt_pkg::ADDR_IRQ_STATUS && prdata[0] && !tallySatEvent
		|=> !irqStatus[tbdt_pkg::IRQ_SAT_BIT])
		else $error("saturation flag not cleared");
	chk_seq_flag: assert property (@(posedge clk_sys) disable iff (reset)
		seqEvent |=> irqStatus[tbdt_pkg::IRQ_SEQ_BIT])
		else $error("sequence flag not set");
	chk_read_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	chk_jabber_speed: assert property (@(posedge clk_sys) disable iff (reset)
		!speed10 |=> !jabberOff)
		else $error("jabber off outside 10M");
	chk_tally_ro: assert property (@(posedge clk_sys) disable iff (reset)
		wrEn && paddr == tbdt_pkg::ADDR_EXT && !selftestRun |=> $stable(selftestErrorTally))
		else $error("tally changed by write");
	cov_saturate: cover property (@(posedge clk_sys) tallySatEvent);
	cov_restart: cover property (@(posedge clk_sys) restart);
	cov_continuous: cover property (@(posedge clk_sys) continuousSend);
	cov_irq: cover property (@(posedge clk_sys) irq);
	cov_gap_end: cover property (@(posedge clk_sys) $fell(sequenceGapActive) && sequenceSend);
endmodule : tbdt_driver_test

// file: tbdt_line_model.sv
// line-side test equipment model: sends errored nibbles on request
// assumes the bench requests a burst right after a clk_sys edge
`timescale 1ns/1ps
module tbdt_line_model (
	// clock
	input wire logic clk_sys,
	// request
	input wire logic errGo,
	input wire logic [8:0] errNum,
	// line side
	output logic nibbleError,
	output logic busy
);
	logic [9:0] left = '0;
	// one errored nibble every other cycle
	always @(posedge clk_sys) begin
		if (errGo)
			left <= {errNum, 1'h0};
		else if (left != 10'h000)
			left <= left - 10'h001;
	end
	assign nibbleError = left[0];
	assign busy = left != 10'h000;
endmodule : tbdt_line_model

// file: tenbase_driver_test_bist_ext_tb_top.sv
// self-checking bench for the driver test and self-test block
// assumes tbdt_pkg and the line model are compiled first
`timescale 1ns/1ps
module tenbase_driver_test_bist_ext_tb_top;
	logic clk_sys = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic speed10 = 1'h0, selftestStart = 1'h0, errGo = 1'h0, busy, nibbleError;
	logic pready, pslverr, patternActive, sequenceGapActive, sequenceSend, continuousSend, jabberOff, irq;
	logic [1:0] patternSelect;
	logic [7:0] paddr = '0, rnd = 8'h5C, val;
	logic [8:0] errNum = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	int n_errors = 0, compares = 0, cycles = 0, n, k, mdlTally = 0;
	always #5 clk_sys = ~clk_sys;
	tbdt_driver_test DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed10(speed10),
		.selftestStart(selftestStart), .nibbleError(nibbleError), .patternActive(patternActive),
		.patternSelect(patternSelect), .sequenceGapActive(sequenceGapActive), .sequenceSend(sequenceSend),
		.continuousSend(continuousSend), .jabberOff(jabberOff), .irq(irq));
	tbdt_line_model line (.clk_sys(clk_sys), .errGo(errGo), .errNum(errNum), .nibbleError(nibbleError),
		.busy(busy));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t mismatch %h expected %h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1)
			@(posedge clk_sys);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task settle;
		repeat (3) @(negedge clk_sys);
	endtask : settle
	task inject(input int cnt);
		@(posedge clk_sys);
		errNum <= cnt[8:0];
		errGo <= 1'h1;
		@(posedge clk_sys);
		errGo <= 1'h0;
		@(negedge clk_sys);
		while (busy)
			@(negedge clk_sys);
		mdlTally = (mdlTally + cnt > 255) ? 255 : mdlTally + cnt;
	endtask : inject
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'h0;
		apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
		check(rd, 32'h0);
		apb(1'h0, 8'h20, '0);
		check(rd, 32'h0);
		check(pslverr, 1'h0);
		@(posedge clk_sys);
		speed10 <= 1'h1;
		// all selects, enabled and not; random continuous and gap bits
		for (n = 0; n < 8; n++) begin
			rnd = lfsr(rnd);
			val = {2'h0, rnd[5], ~n[2], 1'h0, rnd[2], n[1:0]};
			apb(1'h1, tbdt_pkg::ADDR_EXT, {16'h0, 8'hFF, val});
			apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
			check(rd, {24'h0, val});
			settle;
			check(patternActive, val[4]);
			check(patternSelect, val[1:0]);
			check(continuousSend, 1'h0);
			if (n == 3)
				check(sequenceSend, 1'h1);
		end
		// gap length for both settings
		for (n = 0; n < 2; n++) begin
			apb(1'h1, tbdt_pkg::ADDR_EXT, {27'h0, 1'h1, 1'h0, n[0], 2'h0});
			for (k = 0; k < 4000 && sequenceSend !== 1'h1; k++)
				@(negedge clk_sys);
			for (k = 0; k < 4000 && sequenceGapActive !== 1'h1; k++)
				@(negedge clk_sys);
			for (k = 0; k < 4000 && sequenceGapActive === 1'h1; k++)
				@(negedge clk_sys);
			check(k, n ? tbdt_pkg::GAP_LONG_CYC : tbdt_pkg::GAP_SHORT_CYC);
		end
		apb(1'h1, tbdt_pkg::ADDR_CTRL, 32'h1);
		settle;
		check(jabberOff, 1'h1);
		@(posedge clk_sys);
		speed10 <= 1'h0;
		settle;
		check(jabberOff, 1'h0);
		check(patternActive, 1'h0);
		@(posedge clk_sys);
		speed10 <= 1'h1;
		apb(1'h1, tbdt_pkg::ADDR_EXT, 32'h20);
		@(posedge clk_sys);
		selftestStart <= 1'h1;
		settle;
		check(continuousSend, 1'h1);
		// tally, saturation and its interrupt
		apb(1'h1, tbdt_pkg::ADDR_IRQ_MASK, 32'h1);
		apb(1'h0, tbdt_pkg::ADDR_IRQ_STATUS, '0);
		inject(5);
		apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
		check(rd[15:8], mdlTally);
		check(irq, 1'h0);
		inject(300);
		apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
		check(rd[15:8], mdlTally);
		check(irq, 1'h1);
		apb(1'h0, tbdt_pkg::ADDR_IRQ_STATUS, '0);
		check(rd[0], 1'h1);
		settle;
		check(irq, 1'h0);
		inject(3);
		apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
		check(rd[15:8], mdlTally);
		@(posedge clk_sys);
		selftestStart <= 1'h0;
		@(posedge clk_sys);
		selftestStart <= 1'h1;
		mdlTally = 0;
		apb(1'h0, tbdt_pkg::ADDR_EXT, '0);
		check(rd[15:8], mdlTally);
		final_report;
	end
endmodule : tenbase_driver_test_bist_ext_tb_top
